// ---- design/dsc_pkg.sv ----
// Purpose: shared constants for the synth configuration link
// Assumes: 24-bit words, destination in bits 2:0
// Notes: field layout inside each word is fixed here
package dsc_pkg;
  localparam int WORD_W = 24;
  localparam int NREG = 7;
  localparam logic [2:0] ADDR_RF_INT = 3'h0;
  localparam logic [2:0] ADDR_RF_MOD = 3'h1;
  localparam logic [2:0] ADDR_RF_REF = 3'h2;
  localparam logic [2:0] ADDR_MASTER = 3'h3;
  localparam logic [2:0] ADDR_IF_N = 3'h4;
  localparam logic [2:0] ADDR_IF_R = 3'h5;
  localparam logic [2:0] ADDR_IF_CTRL = 3'h6;
  localparam int FRAC_LSB = 3;
  localparam int INT_LSB = 15;
  localparam int MOD_LSB = 3;
  localparam int RF_R_LSB = 3;
  localparam int RF_DBL_BIT = 7;
  localparam int RF_PD_BIT = 5;
  localparam int IF_A_LSB = 3;
  localparam int IF_B_LSB = 9;
  localparam int IF_P_LSB = 21;
  localparam int IF_R_LSB = 3;
  localparam int IF_DBL_BIT = 18;
  localparam int IF_CRST_BIT = 3;
  localparam int IF_PD_BIT = 5;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIV = 8'h08;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_MIN_PERIOD_NS = 50;
  localparam int SCLK_HALF_CYC = (SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DIV_RST = 8'(SCLK_HALF_CYC);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- design/dsc_link_if.sv ----
// Purpose: three-wire serial link between host and synth
// Assumes: host drives every wire
// Notes: no two-way pins
`timescale 1ns/100ps
interface dsc_link_if;
  logic sclk;
  logic serial_data_input;
  logic latch_strobe;
  modport host (output sclk, output serial_data_input, output latch_strobe);
  modport device (input sclk, input serial_data_input, input latch_strobe);
endinterface

// ---- design/dsc_sync.sv ----
// Purpose: two-flop synchroniser with rise detect
// Assumes: inputs from outside the clock domain
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module dsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out,
  output logic [W-1:0] rise
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign sync_out = sync_q;
  assign rise = sync_q & ~last_q;
endmodule

// ---- design/dsc_device.sv ----
// Purpose: synth end, serial latches, power-up gating and dividers
// Assumes: tick inputs come from logic on clk
// Notes: one divider pulse per clk cycle at most
// Operation
// R1: host loads all registers for both sections
// R2: RF only: load 3..0, zero 6..3
// R3: IF powered down until 6..3 loaded
// R4: IF only: load 6..3, zero 3..0
// R5: RF powered down until 3..0 loaded
// R6: RF feedback divides by INT plus FRAC/modulus
// R7: comparison rate is ref times (1+D)/R; code gives at most one pulse per ref tick, so R of 1 with D set gives ref
// R8: IF feedback divides by P times B plus A
// R9: 12-bit modulus, doubler, 4-bit R counter
// R10: host keeps comparison frequency at most 30 MHz
// R11: host raises pump current during frequency jumps
// R12: bits 2:0 of each word pick register
// R13: 24 bits shifted on rise, strobe latches
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module dsc_device (
  input wire logic clk,
  input wire logic reset_n,
  dsc_link_if.device link,
  input wire logic ref_tick,
  input wire logic rf_vco_tick,
  input wire logic if_vco_tick,
  output logic rf_pfd_ref,
  output logic rf_pfd_fb,
  output logic if_pfd_ref,
  output logic if_pfd_fb,
  output logic rf_powered_down,
  output logic if_powered_down,
  output logic [7:0] rf_int,
  output logic [11:0] rf_frac,
  output logic [11:0] fraction_modulus_field,
  output logic [18:0] if_n_ratio,
  output logic [6:0] loaded
);
  logic [2:0] s_level;
  logic [2:0] s_rise;
  logic [dsc_pkg::WORD_W-1:0] shift_q;
  logic [dsc_pkg::WORD_W-1:0] latch_q [dsc_pkg::NREG];
  logic [6:0] loaded_q;
  logic rf_run;
  logic if_run;
  logic [3:0] rf_r;
  logic rf_dbl;
  logic [14:0] if_r;
  logic if_dbl;
  logic [5:0] if_a;
  logic [11:0] if_b;
  logic [1:0] if_p;
  logic [15:0] rf_ref_cnt_q;
  logic [15:0] if_ref_cnt_q;
  logic [16:0] rf_ref_nx;
  logic [16:0] if_ref_nx;
  logic [8:0] rf_fb_cnt_q;
  logic [11:0] acc_q;
  logic carry_q;
  logic [12:0] acc_sum;
  logic [8:0] rf_n_cur;
  logic [18:0] if_fb_cnt_q;

  // pulse flag in the top bit, next count below
  function automatic logic [16:0] ref_step(input logic [15:0] cnt, input logic dbl, input logic [15:0] div);
    logic [16:0] sum;
    logic [16:0] lim;
    sum = 17'(cnt) + 17'h00001 + 17'(dbl);
    lim = (div == 16'h0000) ? 17'h00001 : 17'(div);
    if (sum >= lim) begin
      ref_step = {1'b1, 16'(sum - lim)};
    end else begin
      ref_step = {1'b0, sum[15:0]};
    end
  endfunction

  dsc_sync #(.W(3)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({link.latch_strobe, link.serial_data_input, link.sclk}),
    .sync_out(s_level),
    .rise(s_rise)
  );

  // data and clock share sync latency, so data is stable here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= 24'h000000;
    end else if (s_rise[0]) begin
      shift_q <= {shift_q[dsc_pkg::WORD_W-2:0], s_level[1]}; // R13
    end
  end

  // address 7 names no latch and is dropped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < dsc_pkg::NREG; i++) begin
        latch_q[i] <= 24'h000000;
      end
    end else if (s_rise[2] && shift_q[2:0] != 3'h7) begin
      latch_q[shift_q[2:0]] <= shift_q; // R12 R13
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded_q <= 7'h00;
    end else if (s_rise[2] && shift_q[2:0] != 3'h7) begin
      loaded_q[shift_q[2:0]] <= 1'b1;
    end
  end

  assign loaded = loaded_q;

  // all-zero words count as loads; they can bring the section up
  assign rf_run = (&loaded_q[3:0]) && !latch_q[dsc_pkg::ADDR_MASTER][dsc_pkg::RF_PD_BIT]; // R5
  assign if_run = (&loaded_q[6:3]) && !latch_q[dsc_pkg::ADDR_IF_CTRL][dsc_pkg::IF_PD_BIT]
                  && !latch_q[dsc_pkg::ADDR_IF_CTRL][dsc_pkg::IF_CRST_BIT]; // R3

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rf_powered_down <= 1'b1;
      if_powered_down <= 1'b1;
    end else begin
      rf_powered_down <= !rf_run; // R5
      if_powered_down <= !if_run; // R3
    end
  end

  assign rf_r = latch_q[dsc_pkg::ADDR_RF_REF][dsc_pkg::RF_R_LSB +: 4]; // R9
  assign rf_dbl = latch_q[dsc_pkg::ADDR_RF_REF][dsc_pkg::RF_DBL_BIT];
  assign if_r = latch_q[dsc_pkg::ADDR_IF_R][dsc_pkg::IF_R_LSB +: 15];
  assign if_dbl = latch_q[dsc_pkg::ADDR_IF_R][dsc_pkg::IF_DBL_BIT];
  assign if_a = latch_q[dsc_pkg::ADDR_IF_N][dsc_pkg::IF_A_LSB +: 6];
  assign if_b = latch_q[dsc_pkg::ADDR_IF_N][dsc_pkg::IF_B_LSB +: 12];
  assign if_p = latch_q[dsc_pkg::ADDR_IF_N][dsc_pkg::IF_P_LSB +: 2];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rf_int <= 8'h00;
      rf_frac <= 12'h000;
      fraction_modulus_field <= 12'h000;
      if_n_ratio <= 19'h00000;
    end else begin
      rf_int <= latch_q[dsc_pkg::ADDR_RF_INT][dsc_pkg::INT_LSB +: 8];
      rf_frac <= latch_q[dsc_pkg::ADDR_RF_INT][dsc_pkg::FRAC_LSB +: 12];
      fraction_modulus_field <= latch_q[dsc_pkg::ADDR_RF_MOD][dsc_pkg::MOD_LSB +: 12]; // R9
      // prescaler P is 8 << sel
      if_n_ratio <= (19'(if_b) << (3 + 19'(if_p))) + 19'(if_a); // R8
    end
  end

  // doubling done as a step of two per reference tick
  assign rf_ref_nx = ref_step(rf_ref_cnt_q, rf_dbl, 16'(rf_r)); // R7
  assign if_ref_nx = ref_step(if_ref_cnt_q, if_dbl, 16'(if_r)); // R7

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rf_ref_cnt_q <= 16'h0000;
      rf_pfd_ref <= 1'b0;
    end else if (!rf_run) begin
      rf_ref_cnt_q <= 16'h0000;
      rf_pfd_ref <= 1'b0;
    end else begin
      rf_pfd_ref <= ref_tick && rf_ref_nx[16];
      if (ref_tick) begin
        rf_ref_cnt_q <= rf_ref_nx[15:0]; // R7
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      if_ref_cnt_q <= 16'h0000;
      if_pfd_ref <= 1'b0;
    end else if (!if_run) begin
      if_ref_cnt_q <= 16'h0000;
      if_pfd_ref <= 1'b0;
    end else begin
      if_pfd_ref <= ref_tick && if_ref_nx[16];
      if (ref_tick) begin
        if_ref_cnt_q <= if_ref_nx[15:0]; // R7
      end
    end
  end

  // fractional divider: INT or INT+1, chosen by the modulus accumulator
  assign rf_n_cur = 9'(rf_int) + 9'(carry_q); // R6
  assign acc_sum = 13'(acc_q) + 13'(rf_frac);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rf_fb_cnt_q <= 9'h000;
      acc_q <= 12'h000;
      carry_q <= 1'b0;
      rf_pfd_fb <= 1'b0;
    end else if (!rf_run) begin
      rf_fb_cnt_q <= 9'h000;
      acc_q <= 12'h000;
      carry_q <= 1'b0;
      rf_pfd_fb <= 1'b0;
    end else begin
      rf_pfd_fb <= 1'b0;
      if (rf_vco_tick) begin
        if (rf_fb_cnt_q + 9'h001 >= rf_n_cur) begin
          rf_fb_cnt_q <= 9'h000;
          rf_pfd_fb <= 1'b1;
          if (acc_sum >= 13'(fraction_modulus_field)) begin
            acc_q <= 12'(acc_sum - 13'(fraction_modulus_field)); // R6
            carry_q <= 1'b1;
          end else begin
            acc_q <= acc_sum[11:0];
            carry_q <= 1'b0;
          end
        end else begin
          rf_fb_cnt_q <= rf_fb_cnt_q + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      if_fb_cnt_q <= 19'h00000;
      if_pfd_fb <= 1'b0;
    end else if (!if_run) begin
      if_fb_cnt_q <= 19'h00000;
      if_pfd_fb <= 1'b0;
    end else begin
      if_pfd_fb <= 1'b0;
      if (if_vco_tick) begin
        if (if_fb_cnt_q + 19'h00001 >= if_n_ratio) begin
          if_fb_cnt_q <= 19'h00000;
          if_pfd_fb <= 1'b1; // R8
        end else begin
          if_fb_cnt_q <= if_fb_cnt_q + 19'h00001;
        end
      end
    end
  end
endmodule

// ---- design/dsc_host.sv ----
// Purpose: AXI4-Lite controlled three-wire serial writer
// Assumes: software orders the words as power-up needs
// Notes: one word in flight; data writes while busy get SLVERR
`timescale 1ns/100ps
module dsc_host (
  input wire logic clk,
  input wire logic reset_n,
  dsc_link_if.host link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {DSC_IDLE, DSC_LOW, DSC_HIGH, DSC_STROBE} dsc_state_e;
  dsc_state_e st_q;
  logic [7:0] aw_q;
  logic aw_full_q;
  logic [31:0] w_q;
  logic w_full_q;
  logic [7:0] div_q;
  logic [7:0] tmr_q;
  logic [23:0] sh_q;
  logic [4:0] bit_q;
  logic [6:0] sent_q;
  logic do_wr;
  logic start;
  logic half_done;
  logic word_done;

  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
  assign start = do_wr && aw_q == dsc_pkg::OFS_DATA && st_q == DSC_IDLE;
  assign half_done = tmr_q == 8'h00;
  assign word_done = st_q == DSC_STROBE && half_done;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_q <= 8'h00;
      aw_full_q <= 1'b0;
      w_q <= 32'h00000000;
      w_full_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dsc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        w_full_q <= 1'b1;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ((aw_q == dsc_pkg::OFS_DATA && st_q == DSC_IDLE) || aw_q == dsc_pkg::OFS_STATUS
            || aw_q == dsc_pkg::OFS_DIV) begin
          s_axi_bresp <= dsc_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= dsc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // zero would wrap the timer to the slowest rate, so it is kept at one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= dsc_pkg::DIV_RST;
    end else if (do_wr && aw_q == dsc_pkg::OFS_DIV && s_axi_wstrb[0]) begin
      div_q <= (w_q[7:0] == 8'h00) ? 8'h01 : w_q[7:0];
    end
  end

  // record of words sent, so software can check each power-up set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sent_q <= 7'h00;
    end else begin
      if (do_wr && aw_q == dsc_pkg::OFS_STATUS) begin
        sent_q <= sent_q & ~w_q[7:1];
      end
      if (word_done && sh_q[2:0] != 3'h7) begin
        sent_q[sh_q[2:0]] <= 1'b1; // R1 R2 R4
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= dsc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= dsc_pkg::RESP_OKAY;
      if (s_axi_araddr == dsc_pkg::OFS_STATUS) begin
        s_axi_rdata <= {24'h000000, sent_q, st_q != DSC_IDLE};
      end else if (s_axi_araddr == dsc_pkg::OFS_DIV) begin
        s_axi_rdata <= {24'h000000, div_q};
      end else if (s_axi_araddr == dsc_pkg::OFS_DATA) begin
        s_axi_rdata <= {8'h00, sh_q};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= dsc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // msb first; data set while sclk low, taken on its rise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= DSC_IDLE;
      tmr_q <= 8'h00;
      sh_q <= 24'h000000;
      bit_q <= 5'h00;
      link.sclk <= 1'b0;
      link.serial_data_input <= 1'b0;
      link.latch_strobe <= 1'b0;
    end else begin
      tmr_q <= half_done ? 8'h00 : tmr_q - 8'h01;
      case (st_q)
        DSC_IDLE: begin
          if (start) begin
            sh_q <= w_q[23:0];
            bit_q <= 5'(dsc_pkg::WORD_W);
            link.serial_data_input <= w_q[23];
            tmr_q <= div_q - 8'h01;
            st_q <= DSC_LOW;
          end
        end
        DSC_LOW: begin
          if (half_done) begin
            link.sclk <= 1'b1; // R13
            tmr_q <= div_q - 8'h01;
            bit_q <= bit_q - 5'h01;
            st_q <= DSC_HIGH;
          end
        end
        DSC_HIGH: begin
          if (half_done) begin
            link.sclk <= 1'b0;
            tmr_q <= div_q - 8'h01;
            if (bit_q == 5'h00) begin
              link.latch_strobe <= 1'b1; // R13
              st_q <= DSC_STROBE;
            end else begin
              link.serial_data_input <= sh_q[bit_q - 5'h01];
              st_q <= DSC_LOW;
            end
          end
        end
        DSC_STROBE: begin
          if (half_done) begin
            link.latch_strobe <= 1'b0;
            st_q <= DSC_IDLE;
          end
        end
        default: st_q <= DSC_IDLE;
      endcase
    end
  end
endmodule

// ---- testbench/dsc_link_asserts.sv ----
// Purpose: link framing and power-up checks
// Assumes: wires sampled on clk, host registers them on clk
// Notes: shift copy here mirrors the device input register
`timescale 1ns/100ps
module dsc_link_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic serial_data_input,
  input wire logic latch_strobe,
  input wire logic [6:0] loaded,
  input wire logic rf_powered_down,
  input wire logic if_powered_down,
  input wire logic rf_pfd_fb,
  input wire logic if_pfd_fb
);
  logic sclk_q;
  logic stb_q;
  logic rise_q;
  logic [4:0] cnt_q;
  logic [23:0] sr_q;
  logic [2:0] adr_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      stb_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      stb_q <= latch_strobe;
      rise_q <= latch_strobe && !stb_q;
    end
  end
  // bits counted per frame, cleared while the strobe stands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 5'h00;
    end else if (latch_strobe) begin
      cnt_q <= 5'h00;
    end else if (sclk && !sclk_q) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sr_q <= 24'h000000;
      adr_q <= 3'h0;
    end else begin
      if (sclk && !sclk_q) begin
        sr_q <= {sr_q[22:0], serial_data_input};
      end
      if (latch_strobe && !stb_q) begin
        adr_q <= sr_q[2:0];
      end
    end
  end
  AST_STB_SCLK_LOW: assert property (latch_strobe |-> !sclk)
    else $error("strobe high while sclk high");
  AST_DATA_HELD: assert property ((sclk && sclk_q) |-> $stable(serial_data_input))
    else $error("data moved while sclk high");
  AST_WORD_24: assert property ((latch_strobe && !stb_q) |-> cnt_q == 5'h18)
    else $error("frame not 24 bits");
  AST_LATCH_HIT: assert property ((rise_q && adr_q != 3'h7) |-> ##[0:8] loaded[adr_q])
    else $error("addressed latch not loaded");
  AST_LOAD_KEEP: assert property (($past(loaded) & ~loaded) == 7'h00)
    else $error("loaded bit dropped");
  AST_RF_GATE: assert property (!rf_powered_down |-> &loaded[3:0])
    else $error("rf up before its latches");
  AST_IF_GATE: assert property (!if_powered_down |-> &loaded[6:3])
    else $error("if up before its latches");
  AST_RF_QUIET: assert property (rf_powered_down |-> !rf_pfd_fb)
    else $error("rf feedback pulse while down");
  AST_IF_QUIET: assert property (if_powered_down |-> !if_pfd_fb)
    else $error("if feedback pulse while down");
endmodule

// ---- testbench/dual_synth_config_sequencing_tb.sv ----
// Purpose: host and synth ends joined, driven over AXI4-Lite
// Assumes: field layout of the design notes
// Notes: divider rates measured with ticks every cycle
`timescale 1ns/100ps
module dual_synth_config_sequencing_tb;
  logic clk;
  logic reset_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic tick, rf_ref, rf_fb, if_ref, if_fb, rf_pd, if_pd;
  logic [7:0] rf_int;
  logic [11:0] frac, modv;
  logic [18:0] n_if;
  logic [6:0] loaded;
  int error_cnt = 0;
  int n_tests = 0;
  int c [4];
  logic [23:0] rf_up [4] = '{24'h000003, 24'h0000A2, 24'h000011, 24'h020008};
  logic [23:0] if_up [4] = '{24'h000006, 24'h00002D, 24'h000614, 24'h000003};
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  dsc_link_if dsc_link_if_i ();
  dsc_host dsc_host_i (.clk(clk), .reset_n(reset_n), .link(dsc_link_if_i.host),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  dsc_device dsc_device_i (.clk(clk), .reset_n(reset_n), .link(dsc_link_if_i.device), .ref_tick(tick),
    .rf_vco_tick(tick), .if_vco_tick(tick), .rf_pfd_ref(rf_ref), .rf_pfd_fb(rf_fb), .if_pfd_ref(if_ref),
    .if_pfd_fb(if_fb), .rf_powered_down(rf_pd), .if_powered_down(if_pd), .rf_int(rf_int), .rf_frac(frac),
    .fraction_modulus_field(modv), .if_n_ratio(n_if), .loaded(loaded));
  dsc_link_asserts dsc_link_asserts_i (.clk(clk), .reset_n(reset_n), .sclk(dsc_link_if_i.sclk),
    .serial_data_input(dsc_link_if_i.serial_data_input), .latch_strobe(dsc_link_if_i.latch_strobe),
    .loaded(loaded), .rf_powered_down(rf_pd), .if_powered_down(if_pd), .rf_pfd_fb(rf_fb), .if_pfd_fb(if_fb));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // rates are counted from an arbitrary phase, so allow slack
  task automatic near(input string nm, input int e, input int g);
    n_tests++;
    if (g < e - 2 || g > e + 2) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic late(input int n);
    if (n >= 200) begin
      error_cnt++;
      $display("CHECK FAILED wait expected answer seen timeout");
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_p;
    logic w_p;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((aw_p || w_p) && n < 200) begin
      @(posedge clk);
      n++;
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid && n < 200) begin
      @(posedge clk);
      n++;
    end
    bready <= 1'b0;
    late(n);
    chk("bresp", er, bresp);
  endtask
  task automatic rdw(input logic [7:0] a, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!arready && n < 200);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    rv = rdata;
    late(n);
    chk("rresp", er, rresp);
  endtask
  // polling costs bus cycles but needs no fixed frame length
  task automatic idle();
    int k;
    k = 0;
    do begin
      rdw(dsc_pkg::OFS_STATUS, dsc_pkg::RESP_OKAY);
      k++;
    end while (rv[0] !== 1'b0 && k < 200);
    late(k);
    repeat (8) @(posedge clk);
  endtask
  task automatic send(input logic [23:0] w);
    wr(dsc_pkg::OFS_DATA, {8'h00, w}, dsc_pkg::RESP_OKAY);
    idle();
  endtask
  initial begin
    reset_n = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, tick} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    chk("rf_pd", 1, rf_pd);
    chk("if_pd", 1, if_pd);
    rdw(dsc_pkg::OFS_DIV, dsc_pkg::RESP_OKAY);
    chk("div", {24'h000000, dsc_pkg::DIV_RST}, rv);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      send(rf_up[i]);
      chk("rf_pd", i != 3, rf_pd);
      chk("if_pd", 1, if_pd);
    end
    for (int i = 0; i < 3; i++) begin
      send(if_up[i]);
      chk("if_pd", i != 2, if_pd);
    end
    chk("rf_pd", 0, rf_pd);
    chk("rf_int", 4, rf_int);
    chk("frac", 1, frac);
    chk("mod", 2, modv);
    chk("n_if", 26, n_if);
    rdw(dsc_pkg::OFS_STATUS, dsc_pkg::RESP_OKAY);
    chk("status", 32'h000000FE, rv);
    wr(dsc_pkg::OFS_STATUS, 32'h000000FE, dsc_pkg::RESP_OKAY);
    rdw(dsc_pkg::OFS_STATUS, dsc_pkg::RESP_OKAY);
    chk("status", 0, rv);
    c = '{0, 0, 0, 0};
    tick <= 1'b1;
    repeat (1000) begin
      @(posedge clk);
      c[0] += int'(rf_ref);
      c[1] += int'(rf_fb);
      c[2] += int'(if_ref);
      c[3] += int'(if_fb);
    end
    tick <= 1'b0;
    near("rf_ref", 500, c[0]);
    near("rf_fb", 222, c[1]);
    near("if_ref", 200, c[2]);
    near("if_fb", 38, c[3]);
    $display("test both sections done");
    wr(dsc_pkg::OFS_DATA, 32'h00000007, dsc_pkg::RESP_OKAY);
    wr(dsc_pkg::OFS_DATA, 32'h00000007, dsc_pkg::RESP_SLVERR);
    idle();
    chk("loaded", 7'h7F, loaded);
    wr(8'h10, 32'h00000000, dsc_pkg::RESP_SLVERR);
    rdw(8'h10, dsc_pkg::RESP_SLVERR);
    chk("rdata", 0, rv);
    send(24'h007FF9);
    chk("mod", 12'hFFF, modv);
    send(24'h000023);
    chk("rf_pd", 1, rf_pd);
    send(24'h00000E);
    chk("if_pd", 1, if_pd);
    $display("test refusals and fields done");
    wr(dsc_pkg::OFS_DIV, 32'h00000002, dsc_pkg::RESP_OKAY);
    rdw(dsc_pkg::OFS_DIV, dsc_pkg::RESP_OKAY);
    chk("div", 2, rv);
    send(24'h030008);
    chk("rf_int", 6, rf_int);
    wr(dsc_pkg::OFS_DIV, 32'h00000000, dsc_pkg::RESP_OKAY);
    rdw(dsc_pkg::OFS_DIV, dsc_pkg::RESP_OKAY);
    chk("div", 1, rv);
    // jump made with the if pump at its top setting, then set back low
    send(24'h000706);
    chk("if_pd", 0, if_pd);
    send(24'h200614);
    chk("n_if", 50, n_if);
    send(24'h000006);
    send(24'h000614);
    chk("n_if", 26, n_if);
    rdw(dsc_pkg::OFS_DATA, dsc_pkg::RESP_OKAY);
    chk("data", 32'h00000614, rv);
    $display("test divider done");
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    chk("loaded", 0, loaded);
    for (int i = 0; i < 4; i++) begin
      send(if_up[i]);
      chk("if_pd", i != 3, if_pd);
      chk("rf_pd", 1, rf_pd);
    end
    for (int i = 2; i >= 0; i--) begin
      send({21'h000000, 3'(i)});
      chk("rf_pd", i != 0, rf_pd);
    end
    chk("loaded", 7'h7F, loaded);
    $display("test if only done");
    conclude();
  end
endmodule
